//--- dfs_pkg.sv
// dfs_pkg: constants, types and register map of the filter timing block
package dfs_pkg;
	// wishbone register byte offsets
	localparam logic [4:0] DFS_CTRL_OFS  = 5'h00;
	localparam logic [4:0] DFS_STAT_OFS  = 5'h04;
	localparam logic [4:0] DFS_IRQS_OFS  = 5'h08;
	localparam logic [4:0] DFS_IRQM_OFS  = 5'h0C;
	localparam logic [4:0] DFS_WORD_OFS  = 5'h10;
	// control register bit positions
	localparam int DFS_CTRL_LPWR   = 0;
	localparam int DFS_CTRL_DEC256 = 1;
	localparam int DFS_CTRL_AMPOFF = 2;
	localparam int DFS_CTRL_W      = 3;
	localparam logic [2:0] DFS_CTRL_RST = 3'h0;
	// interrupt bits: frame emitted, filter settled
	localparam int DFS_IRQ_FRAME  = 0;
	localparam int DFS_IRQ_SETTLE = 1;
	localparam int DFS_IRQ_W      = 2;
	// timing in master clock periods, one period per sys_clk
	localparam logic [14:0] DFS_OFS_N128 = 15'd141;
	localparam logic [14:0] DFS_OFS_N256 = 15'd252;
	localparam logic [14:0] DFS_OFS_L128 = 15'd167;
	localparam logic [14:0] DFS_OFS_L256 = 15'd277;
	// output word periods
	localparam logic [8:0] DFS_PER_128 = 9'd128;
	localparam logic [8:0] DFS_PER_256 = 9'd256;
	// frame output held low for 32 serial clocks of two periods each
	localparam logic [8:0] DFS_FRAME_LOW = 9'd64;
	// sample history depth, covers the longest group delay in words
	localparam int DFS_HIST = 64;
	localparam int DFS_HW   = 6;
	// decimation code bit: one for 128x
	localparam logic DFS_DEC0_128 = 1'b1;
	// sequencer states
	typedef enum logic [1:0] {DFS_HOLD, DFS_WAIT, DFS_RUN} dfs_seq_e;
	// output word layout
	typedef struct packed {
		logic [23:0] data;   // two's complement result
		logic        settled;
		logic        ovr;
		logic        lpwr;
		logic        dec1;
		logic        dec0;
		logic [2:0]  zero;
	} dfs_word_s;
	// per-mode timing selection
	typedef struct packed {
		logic [14:0] ofs;
		logic [14:0] settle;
		logic [14:0] gd;
		logic [8:0]  per;
	} dfs_tim_s;
endpackage : dfs_pkg

//--- dfs_top.sv
// dfs_top: decimation filter restart, frame timing and output word logic
`timescale 1ns/1ps
// How it works
// - normal 128x: frame 141, settled 13966
// - normal 256x: frame 252, settled 27901
// - low power: frames 167/277, settle 14248/27926
// - normal group delay 7073 or 14051
// - low power group delay 7170 or 14144
// - modulator clock half or quarter master
// - word rate master over 128 or 256
// - result is 24-bit two's complement
// - amplifier-off bit powers amplifier down
// - restart low holds sequencer at zero
// - settled bit 7 clears in the first word after restart, sets later
module dfs_top import dfs_pkg::*; #(
	parameter logic [14:0] SETTLE_N128 = 15'd13966,
	parameter logic [14:0] SETTLE_N256 = 15'd27901,
	parameter logic [14:0] SETTLE_L128 = 15'd14248,
	parameter logic [14:0] SETTLE_L256 = 15'd27926,
	parameter logic [14:0] GD_N128     = 15'd7073,
	parameter logic [14:0] GD_N256     = 15'd14051,
	parameter logic [14:0] GD_L128     = 15'd7170,
	parameter logic [14:0] GD_L256     = 15'd14144
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// restart pin and modulator result
	input  wire logic        restart_n,
	input  wire logic [23:0] mod_data,
	// outputs
	output logic             modulator_clock,
	output logic             frame_out_n,
	output dfs_word_s        out_word,
	output logic             input_amp_powerdown,
	output logic             irq
);
	// restart synchroniser, three stages
	logic       s1_reg, s2_reg, s3_reg, rlvl_reg;
	logic       rlvl_next;
	// control, interrupt and bus state
	logic [2:0] ctrl_reg, ctrl_next;
	logic [DFS_IRQ_W-1:0] ist_reg, ist_next, imsk_reg, imsk_next;
	logic [31:0] rd_reg, rd_next;
	logic       ack_reg, ack_next, irq_reg, irq_next;
	// sequencer
	dfs_seq_e   st_reg, st_next;
	logic [14:0] cnt_reg, cnt_next;
	logic [8:0] ph_reg, ph_next;
	logic [8:0] low_reg, low_next;  // frame low-time counter
	logic       set_reg, set_next;  // filter settled
	logic       fo_reg, fo_next;    // frame output, active low
	logic [1:0] mdiv_reg, mdiv_next;
	logic       mclk_reg, mclk_next;
	dfs_word_s  word_reg, word_next;
	// sample history
	logic [23:0] hist [DFS_HIST];
	logic [DFS_HW-1:0] wp_reg, wp_next;
	// combinational helpers
	dfs_tim_s   tim;
	logic       frame_evt, cap_evt, hold, wr_acc;
	logic [14:0] depth, off;
	logic [8:0] cap_ph;
	logic [DFS_HW-1:0] rp;

	// three flops; level moves only when stages two and three agree
	always_comb begin
		rlvl_next = rlvl_reg;
		if (s2_reg == s3_reg) begin
			rlvl_next = s3_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_reg   <= 1'b0;
			s2_reg   <= 1'b0;
			s3_reg   <= 1'b0;
			rlvl_reg <= 1'b0;
		end else begin
			s1_reg   <= restart_n;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			rlvl_reg <= rlvl_next;
		end
	end

	// mode-dependent limits
	always_comb begin
		case ({ctrl_reg[DFS_CTRL_LPWR], ctrl_reg[DFS_CTRL_DEC256]})
			2'b00: tim = '{DFS_OFS_N128, SETTLE_N128, GD_N128,
				DFS_PER_128};
			2'b01: tim = '{DFS_OFS_N256, SETTLE_N256, GD_N256,
				DFS_PER_256};
			2'b10: tim = '{DFS_OFS_L128, SETTLE_L128, GD_L128,
				DFS_PER_128};
			default: tim = '{DFS_OFS_L256, SETTLE_L256, GD_L256,
				DFS_PER_256};
		endcase
	end

	// group delay split into whole words and a phase lead
	always_comb begin
		depth  = tim.gd / {6'h00, tim.per};
		off    = tim.gd % {6'h00, tim.per};
		cap_ph = tim.per - 9'd1 - off[8:0];
		// step one entry further back: the newest entry is this word's
		// own capture, unless the capture falls on the frame edge itself
		rp     = wp_reg - depth[DFS_HW-1:0]
			- ((off == 15'd0) ? DFS_HW'(0) : DFS_HW'(1));
	end

	// bus decode; a write that changes the mode restarts the filter like the pin
	always_comb begin
		wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & wb_sel_i[0];
		hold = ~rlvl_reg | (wr_acc && wb_adr_i == DFS_CTRL_OFS &&
			wb_dat_i[1:0] != ctrl_reg[1:0]);
	end

	// sequencer: one counter from restart release
	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		ph_next   = ph_reg;
		set_next  = set_reg;
		frame_evt = 1'b0;
		cap_evt   = 1'b0;
		case (st_reg)
			DFS_HOLD: begin
				st_next = DFS_WAIT;
			end
			DFS_WAIT: begin
				// first frame after the offset
				if (cnt_reg == tim.ofs - 15'd1) begin
					frame_evt = 1'b1;
					st_next   = DFS_RUN;
					ph_next   = 9'd0;
				end
			end
			DFS_RUN: begin
				// one word every period
				ph_next   = (ph_reg == tim.per - 9'd1) ? 9'd0
					: ph_reg + 9'd1;
				frame_evt = (ph_reg == tim.per - 9'd1);
				cap_evt   = (ph_reg == cap_ph);
			end
			default: begin
				st_next = DFS_HOLD;
			end
		endcase
		// counter saturates at the settle limit
		if (st_reg != DFS_HOLD && cnt_reg != tim.settle) begin
			cnt_next = cnt_reg + 15'd1;
		end
		if (st_reg != DFS_HOLD && cnt_reg == tim.settle - 15'd1) begin
			set_next = 1'b1;
		end
		// restart wins over state, count, phase and settled flag
		if (hold) begin
			st_next  = DFS_HOLD;
			cnt_next = 15'd0;
			ph_next  = 9'd0;
			set_next = 1'b0;
		end
	end

	// frame pulse, output word, modulator clock divider
	always_comb begin
		low_next  = (low_reg != 9'd0) ? low_reg - 9'd1 : 9'd0;
		fo_next   = (low_reg <= 9'd1);
		word_next = word_reg;
		wp_next   = cap_evt ? wp_reg + 1'b1 : wp_reg;
		if (frame_evt) begin
			low_next          = DFS_FRAME_LOW;
			fo_next           = 1'b0;
			word_next.data    = hist[rp];
			word_next.settled = set_next;
			word_next.ovr     = 1'b0;
			word_next.lpwr    = ctrl_reg[DFS_CTRL_LPWR];
			word_next.dec1    = 1'b0;
			word_next.dec0    = ctrl_reg[DFS_CTRL_DEC256]
				? ~DFS_DEC0_128 : DFS_DEC0_128;
			word_next.zero    = 3'h0;
		end
		// half rate toggles each cycle, quarter every second
		mdiv_next = mdiv_reg + 2'd1;
		mclk_next = ctrl_reg[DFS_CTRL_LPWR] ? mdiv_next[1]
			: mdiv_next[0];
		if (hold) begin
			low_next  = 9'd0;
			fo_next   = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg   <= DFS_HOLD;
			cnt_reg  <= 15'd0;
			ph_reg   <= 9'd0;
			set_reg  <= 1'b0;
			low_reg  <= 9'd0;
			fo_reg   <= 1'b1;
			word_reg <= '0;
			wp_reg   <= '0;
			mdiv_reg <= 2'd0;
			mclk_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			ph_reg   <= ph_next;
			set_reg  <= set_next;
			low_reg  <= low_next;
			fo_reg   <= fo_next;
			word_reg <= word_next;
			wp_reg   <= wp_next;
			mdiv_reg <= mdiv_next;
			mclk_reg <= mclk_next;
		end
	end

	// history: one entry per word, written at the capture phase
	for (genvar i = 0; i < DFS_HIST; i++) begin : g_hist
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				hist[i] <= 24'h00_0000;
			end else if (cap_evt && wp_reg == DFS_HW'(i)) begin
				hist[i] <= mod_data;
			end
		end
	end

	// registers, interrupts and bus answer
	always_comb begin
		ctrl_next = ctrl_reg;
		imsk_next = imsk_reg;
		ist_next  = ist_reg;
		rd_next   = rd_reg;
		ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
		if (wr_acc) begin
			case (wb_adr_i)
				DFS_CTRL_OFS: ctrl_next = wb_dat_i[DFS_CTRL_W-1:0];
				DFS_IRQS_OFS: ist_next = ist_reg
					& ~wb_dat_i[DFS_IRQ_W-1:0];
				DFS_IRQM_OFS: imsk_next = wb_dat_i[DFS_IRQ_W-1:0];
				default: ;
			endcase
		end
		// events set after the clear so a set wins
		if (frame_evt) begin
			ist_next[DFS_IRQ_FRAME] = 1'b1;
		end
		if (set_next && !set_reg) begin
			ist_next[DFS_IRQ_SETTLE] = 1'b1;
		end
		irq_next = |(ist_next & imsk_next);
		if (ack_next) begin
			case (wb_adr_i)
				DFS_CTRL_OFS: rd_next = {29'h0, ctrl_reg};
				DFS_STAT_OFS: rd_next = {30'h0, st_reg == DFS_RUN,
					set_reg};
				DFS_IRQS_OFS: rd_next = {30'h0, ist_reg};
				DFS_IRQM_OFS: rd_next = {30'h0, imsk_reg};
				DFS_WORD_OFS: rd_next = word_reg;
				default:      rd_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_reg <= DFS_CTRL_RST;
			imsk_reg <= '0;
			ist_reg  <= '0;
			rd_reg   <= 32'h0000_0000;
			ack_reg  <= 1'b0;
			irq_reg  <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			imsk_reg <= imsk_next;
			ist_reg  <= ist_next;
			rd_reg   <= rd_next;
			ack_reg  <= ack_next;
			irq_reg  <= irq_next;
		end
	end

	// outputs, all straight from flops
	assign wb_dat_o            = rd_reg;
	assign wb_ack_o            = ack_reg;
	assign modulator_clock     = mclk_reg;
	assign frame_out_n         = fo_reg;
	assign out_word            = word_reg;
	assign input_amp_powerdown = ctrl_reg[DFS_CTRL_AMPOFF];
	assign irq                 = irq_reg;

	// helper: cycles since the previous frame
	logic [8:0] gap_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || frame_evt || hold) begin
			gap_reg <= 9'd1;
		end else if (gap_reg != 9'h1FF) begin
			gap_reg <= gap_reg + 9'd1;
		end
	end

	sequence s_first_frame;
		st_reg == DFS_WAIT && cnt_reg == tim.ofs - 15'd1 && !hold;
	endsequence
	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !ack_reg;
	endsequence

	chk_first_frame: assert property (@(posedge sys_clk)
		disable iff (sys_rst) s_first_frame |=> !fo_reg
		&& cnt_reg == tim.ofs && st_reg == DFS_RUN)
		else $error("first frame not at offset");
	chk_settle_time: assert property (@(posedge sys_clk)
		disable iff (sys_rst) $rose(set_reg) |-> cnt_reg == tim.settle)
		else $error("settled flag at wrong count");
	chk_word_rate: assert property (@(posedge sys_clk)
		disable iff (sys_rst) frame_evt && st_reg == DFS_RUN && !hold
		|-> gap_reg == tim.per)
		else $error("frame spacing wrong");
	chk_restart_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !rlvl_reg |=> cnt_reg == 15'd0
		&& !set_reg && fo_reg)
		else $error("restart did not hold sequencer");
	// both toggles of the pair must have been made in normal mode
	chk_modclk_div: assert property (@(posedge sys_clk)
		disable iff (sys_rst) ##1 !$past(ctrl_reg[DFS_CTRL_LPWR])
		&& !$past(ctrl_reg[DFS_CTRL_LPWR], 2)
		|-> mclk_reg != $past(mclk_reg))
		else $error("modulator clock not half rate");
	chk_input_amp_powerdown: assert property (@(posedge sys_clk)
		disable iff (sys_rst) wr_acc && wb_adr_i == DFS_CTRL_OFS
		|=> input_amp_powerdown == $past(wb_dat_i[DFS_CTRL_AMPOFF]))
		else $error("amplifier bit not applied");
	chk_word_format: assert property (@(posedge sys_clk)
		disable iff (sys_rst) $fell(fo_reg) |-> out_word.zero == 3'h0
		&& out_word.settled == set_reg
		&& out_word.lpwr == ctrl_reg[DFS_CTRL_LPWR])
		else $error("output word format wrong");
	chk_bus_ack: assert property (@(posedge sys_clk)
		disable iff (sys_rst) s_bus_req |=> ack_reg ##1 !ack_reg)
		else $error("bus ack not single cycle");
	chk_frame_low: assert property (@(posedge sys_clk)
		disable iff (sys_rst || hold) $fell(fo_reg) |-> !fo_reg [*8])
		else $error("frame low too short");
endmodule : dfs_top

//--- dfs_host_model.sv
// dfs_host_model: host side model that drives the restart pin
`timescale 1ns/1ps
module dfs_host_model (
	// master clock from the bench
	input  wire logic sys_clk,
	// restart pin towards the filter block
	output logic      restart_n
);
	// idle level: not restarting
	initial restart_n = 1'b1;

	// hold restart low for n periods, never fewer than four
	// callers sit on a rising edge, so pin changes land just after it
	task automatic restart_pulse(input int n);
		int k;
		restart_n <= 1'b0;
		for (k = 0; k < ((n < 4) ? 4 : n); k++) begin
			@(posedge sys_clk);
		end
		restart_n <= 1'b1;
	endtask : restart_pulse
endmodule : dfs_host_model

//--- dfs_top_tb.sv
// dfs_top_tb: self-checking bench for the filter timing block
`timescale 1ns/1ps
module dfs_top_tb import dfs_pkg::*; ;
	// design inputs and outputs
	logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [4:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        wb_ack_o, restart_n, modulator_clock, frame_out_n;
	logic        input_amp_powerdown, irq, mc;
	logic [23:0] mod_data;
	dfs_word_s   out_word;
	// counters and marks
	int          bad_count, n_tests, cyc_n, mark, t, i, j;
	// one row per mode: control, offset, settle, word period, group
	// delay, input
	typedef struct {logic [2:0] c; int o; int s; int p; int g;
		logic [23:0] d;} dfs_row_s;
	dfs_row_s    rows [4];

	// full timing throughout; the settle waits dominate the run time
	dfs_top dfs_top_inst (
		.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .restart_n, .mod_data,
		.modulator_clock, .frame_out_n, .out_word, .input_amp_powerdown,
		.irq);
	dfs_host_model dfs_host_model_inst (.sys_clk, .restart_n);

	// 100 MHz master clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// free running cycle count, read only on falling edges
	always @(posedge sys_clk) cyc_n <= cyc_n + 1;

	// value compare
	task automatic chk(input logic [31:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	// cycle count compare against a window
	task automatic rng(input int g, lo, hi, input string m);
		n_tests++;
		if (g < lo || g > hi) begin
			bad_count++;
			$display("BAD %0t %s got %0d exp %0d..%0d", $time, m, g, lo, hi);
		end
	endtask : rng
	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// classic wishbone cycle, entered on a rising edge
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// ack and read data taken at the rising edge that samples ack
		for (k = 0; k < 20; k++) begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'b1) begin
				break;
			end
		end
		if (k == 20) begin
			bad_count++;
			finish_test();
		end
		rd = wb_dat_o;
		// release, then cyc and stb stay low across one edge
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask : wb
	// bounded wait: 0 frame falls, 1 frame rises, 2 irq high
	task automatic wfor(input int s);
		int k;
		// long enough for the slowest settle time
		for (k = 0; k < 30000; k++) begin
			@(negedge sys_clk);
			if ((s == 0 && frame_out_n === 1'b0) ||
				(s == 1 && frame_out_n === 1'b1) || (s == 2 && irq === 1'b1))
				break;
		end
		if (k == 30000) begin
			bad_count++;
			finish_test();
		end
	endtask : wfor

	// main sequence
	initial begin
		rows = '{'{3'h0, 141, 13966, 128, 7073, 24'h12_3456},
			'{3'h2, 252, 27901, 256, 14051, 24'hFE_DCBA},
			'{3'h1, 167, 14248, 128, 7170, 24'h80_0000},
			'{3'h7, 277, 27926, 256, 14144, 24'h7F_FFFF}};
		{sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_dat_i, mod_data} = '0;
		wb_sel_i = 4'hF;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		// registers other than status read zero after reset
		for (i = 0; i < 5; i++) begin
			if (i != 1) wb(1'b0, 5'(4 * i), 32'h0000_0000);
			if (i != 1) chk(rd, 32'h0000_0000, "reset value");
		end
		// one pass per power mode and decimation
		foreach (rows[r]) begin
			mod_data <= rows[r].d;
			wb(1'b1, DFS_IRQM_OFS, 32'h0000_0002);
			wb(1'b1, DFS_CTRL_OFS, {29'h0, rows[r].c});
			chk(input_amp_powerdown, rows[r].c[2], "input_amp_powerdown");
			wb(1'b1, DFS_IRQS_OFS, 32'h0000_0003);
			dfs_host_model_inst.restart_pulse(5);
			@(negedge sys_clk);
			mark = cyc_n;
			wfor(1);
			wfor(0);
			rng(cyc_n - mark, rows[r].o, rows[r].o + 6, "offset");
			chk(out_word.settled, 1'b0, "early settled");
			chk({out_word.ovr, out_word.dec1, out_word.lpwr, out_word.dec0,
				out_word.zero}, {2'b00, rows[r].c[0], ~rows[r].c[1], 3'h0},
				"status");
			t = cyc_n;
			wfor(1);
			rng(cyc_n - t, 64, 64, "frame low");
			wfor(0);
			rng(cyc_n - t, rows[r].p, rows[r].p, "word rate");
			// modulator clock half period: one or two master periods
			mc = modulator_clock;
			for (j = 0; j < 8 && modulator_clock === mc; j++) @(negedge sys_clk);
			mc = modulator_clock;
			t = cyc_n;
			for (j = 0; j < 8 && modulator_clock === mc; j++) @(negedge sys_clk);
			rng(cyc_n - t, rows[r].c[0] + 1, rows[r].c[0] + 1, "mod clk");
			wfor(2);
			rng(cyc_n - mark, rows[r].s, rows[r].s + 8, "settle");
			@(posedge sys_clk);
			wb(1'b0, DFS_STAT_OFS, 32'h0000_0000);
			chk(rd, 32'h0000_0003, "status reg");
			wfor(1);
			wfor(0);
			chk(out_word.settled, 1'b1, "settled bit");
			chk(out_word.data, rows[r].d, "result");
			@(posedge sys_clk);
			wb(1'b1, DFS_IRQS_OFS, 32'h0000_0002);
			chk(irq, 1'b0, "irq clear");
			wb(1'b0, DFS_IRQS_OFS, 32'h0000_0000);
			chk(rd[1:0], 2'b01, "sticky events");
			// group delay once, normal 128x: step the input, time the word
			if (r == 0) begin
				mod_data <= ~rows[r].d;
				@(negedge sys_clk);
				t = cyc_n;
				for (j = 0; j < 70 && out_word.data !== ~rows[r].d; j++) begin
					wfor(1);
					wfor(0);
				end
				rng(cyc_n - t, rows[r].g, rows[r].g + rows[r].p, "group delay");
				@(posedge sys_clk);
			end
		end
		// restart in mid-run: run and settled status bits held at zero
		fork
			dfs_host_model_inst.restart_pulse(150);
			begin
				repeat (10) @(posedge sys_clk);
				wb(1'b0, DFS_STAT_OFS, 32'h0000_0000);
				chk(rd, 32'h0000_0000, "held status");
			end
		join
		// write without byte lane zero is ignored
		wb_sel_i <= 4'hE;
		wb(1'b1, DFS_CTRL_OFS, 32'h0000_0000);
		wb_sel_i <= 4'hF;
		// unmapped place: write ignored, read zero, control untouched
		wb(1'b1, 5'h14, 32'hFFFF_FFFF);
		wb(1'b0, 5'h14, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped");
		wb(1'b0, DFS_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0007, "ctrl kept");
		// second reset in mid-run
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({frame_out_n, irq, input_amp_powerdown}, 3'h4, "in reset");
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		wb(1'b0, DFS_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "ctrl reset");
		finish_test();
	end
endmodule : dfs_top_tb
